// ---- pkg/nfc_pkg.sv ----
// What this block does
// - Write counts only with chip-select and write-strobe low, output-enable high.
// - Controller issues erase resume to leave erase suspension.
// - On timeout-fail flag controller must reset device to restore read mode.
// - Id and query modes persist until reset; the controller issues no reset before array reads, the host requests OP_SWRESET.
// - Program is two unlock cycles, program code, then address with data.
// - Reset pin low for minimum width; wait ready time while busy is low.
package nfc_pkg;

  // ---------------------------------------------------------------
  // Timing (50 MHz clock)
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 50;
  localparam int T_STROBE_NS     = 60;   // Strobe low / setup phase
  localparam int T_STROBE_CYC    = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RESET_NS      = 500;  // Minimum reset pulse width
  localparam int T_RESET_CYC     = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int T_READY_US      = 20;   // Reset ready time
  localparam int T_READY_CYC     = T_READY_US * CLK_MHZ;
  localparam int T_PWRUP_US      = 50;   // Power-up settle wait
  localparam int T_PWRUP_CYC     = T_PWRUP_US * CLK_MHZ;
  localparam int CNT_W           = 16;

  // ---------------------------------------------------------------
  // Command codes and unlock cycles
  // ---------------------------------------------------------------
  localparam logic [22:0] UNLOCK1_ADDR = 23'h000555;
  localparam logic [22:0] UNLOCK2_ADDR = 23'h0002aa;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM  = 16'h00a0;
  localparam logic [15:0] CMD_SUSPEND  = 16'h00b0;
  localparam logic [15:0] CMD_RESUME   = 16'h0030;
  localparam logic [15:0] CMD_RESET    = 16'h00f0;

  // ---------------------------------------------------------------
  // Wishbone register map (word offsets as byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;  // W: go, op
  localparam logic [3:0] REG_ADDR   = 4'h4;  // Flash address
  localparam logic [3:0] REG_WDATA  = 4'h8;  // Write data
  localparam logic [3:0] REG_STATUS = 4'hc;  // R: status, read data
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_OP_LSB   = 1;
  localparam int CTRL_IDSEL_BIT = 4;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_FAIL_BIT   = 1;
  localparam int ST_LOCK_BIT   = 2;
  localparam int ST_RDY_BIT    = 3;
  localparam int ST_DATA_LSB   = 16;

  typedef enum logic [2:0] {
    OP_READ, OP_PROGRAM, OP_SUSPEND, OP_RESUME, OP_SWRESET, OP_HWRESET, OP_POLL
  } nfc_op_t;

  // Flash pin bundle from controller
  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        rst_n;
    logic        id_hv;      // High-voltage request on id_select_address_bit
    logic [22:0] addr;
  } nfc_pins_t;

  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] dat;
  } nfc_wb_req_t;

endpackage

// ---- rtl/nfc_seq_rom.sv ----
`timescale 1ns/1ns
// Small sequence table: address and data of each bus cycle of a command
module nfc_seq_rom (
  input  wire logic                clock_i,  // System clock
  input  wire logic [2:0]          op_i,     // Operation
  input  wire logic [1:0]          idx_i,    // Cycle index
  input  wire logic [22:0]         uaddr_i,  // User address
  input  wire logic [15:0]         udata_i,  // User data
  output logic      [22:0]         addr_o,   // Registered cycle address
  output logic      [15:0]         data_o,   // Registered cycle data
  output logic      [1:0]          last_o    // Registered last index
);
  import nfc_pkg::*;

  logic [22:0] addr_nxt;
  logic [15:0] data_nxt;
  logic [1:0]  last_nxt;

  // Table lookup
  always_comb begin
    addr_nxt = uaddr_i;
    data_nxt = udata_i;
    last_nxt = 2'h0;
    case (nfc_op_t'(op_i))
      OP_PROGRAM: begin
        last_nxt = 2'h3;
        case (idx_i)
          2'h0: begin addr_nxt = UNLOCK1_ADDR; data_nxt = UNLOCK1_DATA; end
          2'h1: begin addr_nxt = UNLOCK2_ADDR; data_nxt = UNLOCK2_DATA; end
          2'h2: begin addr_nxt = UNLOCK1_ADDR; data_nxt = CMD_PROGRAM;  end
          default: begin addr_nxt = uaddr_i; data_nxt = udata_i; end
        endcase
      end
      OP_SUSPEND: data_nxt = CMD_SUSPEND;
      OP_RESUME:  data_nxt = CMD_RESUME;
      OP_SWRESET: data_nxt = CMD_RESET;
      default:    data_nxt = udata_i;
    endcase
  end

  // Registered read out
  always_ff @(posedge clock_i) begin
    addr_o <= addr_nxt;
    data_o <= data_nxt;
    last_o <= last_nxt;
  end
endmodule

// ---- rtl/nfc_ctrl.sv ----
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
// Host controller for an asynchronous NOR flash, commanded over Wishbone
module nfc_ctrl (
  input  wire logic                 clock_i,     // 50 MHz clock
  input  wire logic                 nrst_i,      // Sync reset, active low
  input  wire nfc_pkg::nfc_wb_req_t wb_i,        // Wishbone request
  output logic      [31:0]          wb_dat_o,    // Wishbone read data
  output logic                      wb_ack_o,    // Wishbone ack
  output nfc_pkg::nfc_pins_t        pins_o,      // Flash control/address pins
  output logic      [15:0]          dq_o,        // Data pins out
  output logic                      dq_oe_n_o,   // Data pins enable, low drives
  input  wire logic [15:0]          dq_i,        // Data pins in
  input  wire logic                 ready_busy_n_i, // Flash ready/busy
  input  wire logic                 lockout_i    // Supply lockout indication
);
  import nfc_pkg::*;

  typedef enum logic [2:0] {
    S_PWRUP, S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RSTLOW, S_RSTWAIT
  } nfc_state_t;

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  logic [15:0] dq_s1_r, dq_s2_r;
  logic        rb_s1_r, rb_s2_r, lk_s1_r, lk_s2_r;
  always_ff @(posedge clock_i) begin
    dq_s1_r <= dq_i;
    dq_s2_r <= dq_s1_r;
    rb_s1_r <= ready_busy_n_i;
    rb_s2_r <= rb_s1_r;
    lk_s1_r <= lockout_i;
    lk_s2_r <= lk_s1_r;
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  nfc_state_t   st_r, st_nxt;
  logic [2:0]   op_r;
  logic         idsel_r;
  logic [22:0]  uaddr_r;
  logic [15:0]  udata_r;
  logic [15:0]  rdata_r;
  logic         fail_r;
  logic         go_r;
  logic [1:0]   idx_r;
  logic [CNT_W-1:0] cnt_r;
  logic [22:0]  seq_addr;
  logic [15:0]  seq_data;
  logic [1:0]   seq_last;

  nfc_seq_rom u_rom (
    .clock_i (clock_i),
    .op_i    (op_r),
    .idx_i   (idx_r),
    .uaddr_i (uaddr_r),
    .udata_i (udata_r),
    .addr_o  (seq_addr),
    .data_o  (seq_data),
    .last_o  (seq_last)
  );

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  wire wb_req    = wb_i.cyc & wb_i.stb & ~wb_ack_o;
  wire wb_wr     = wb_req & wb_i.we;
  wire hit_ctrl  = wb_i.adr == REG_CTRL;
  wire hit_addr  = wb_i.adr == REG_ADDR;
  wire hit_wdata = wb_i.adr == REG_WDATA;
  wire hit_stat  = wb_i.adr == REG_STATUS;
  wire busy      = st_r != S_IDLE;
  // Go accepted only when idle and supply is good
  wire go_take   = wb_wr & hit_ctrl & wb_i.sel[0] & wb_i.dat[CTRL_GO_BIT]
                   & ~busy & ~lk_s2_r;
  wire is_read   = (nfc_op_t'(op_r) == OP_READ) || (nfc_op_t'(op_r) == OP_POLL);
  wire cnt_done  = cnt_r == '0;
  // Timeout flag counts only on status polls, never on array data
  wire fail_seen = (nfc_op_t'(op_r) == OP_POLL) & dq_s2_r[5];
  wire [31:0] stat_word = {rdata_r, 12'h000,
                           rb_s2_r, lk_s2_r, fail_r, busy};

  // -----------------------------------------------------------------
  // Bus slave: one wait state, ack for one cycle
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_i.we) begin
        if (hit_stat)       wb_dat_o <= stat_word;
        else if (hit_addr)  wb_dat_o <= {9'h000, uaddr_r};
        else if (hit_wdata) wb_dat_o <= {16'h0000, udata_r};
        else                wb_dat_o <= {27'h0, idsel_r, op_r, 1'b0};
      end
    end
  end

  // Register writes
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      uaddr_r <= 23'h0;
      udata_r <= 16'h0;
      op_r    <= 3'h0;
      idsel_r <= 1'b0;
    end else if (wb_wr && !busy) begin
      if (hit_addr)  uaddr_r <= wb_i.dat[22:0];
      if (hit_wdata) udata_r <= wb_i.dat[15:0];
      if (hit_ctrl) begin
        op_r    <= wb_i.dat[CTRL_OP_LSB +: 3];
        idsel_r <= wb_i.dat[CTRL_IDSEL_BIT];
      end
    end
  end

  // -----------------------------------------------------------------
  // Sequencer next state
  // -----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_PWRUP:   if (cnt_done) st_nxt = S_IDLE;
      S_IDLE:    if (go_r) st_nxt = (nfc_op_t'(op_r) == OP_HWRESET) ? S_RSTLOW : S_SETUP;
      S_SETUP:   if (cnt_done) st_nxt = S_STROBE;
      S_STROBE:  if (cnt_done) st_nxt = S_HOLD;
      S_HOLD:    if (cnt_done) st_nxt = (idx_r == seq_last) ? S_IDLE : S_SETUP;
      S_RSTLOW:  if (cnt_done) st_nxt = S_RSTWAIT;
      S_RSTWAIT: if (cnt_done || rb_s2_r) st_nxt = S_IDLE;
      default:   st_nxt = S_IDLE;
    endcase
  end

  // State, counter, pin drive
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_r      <= S_PWRUP;
      cnt_r     <= CNT_W'(T_PWRUP_CYC);
      go_r      <= 1'b0;
      idx_r     <= 2'h0;
      fail_r    <= 1'b0;
      rdata_r   <= 16'h0;
      pins_o    <= '{ce_n:1'b1, we_n:1'b1, oe_n:1'b1, rst_n:1'b1, id_hv:1'b0, addr:23'h0};
      dq_o      <= 16'h0;
      dq_oe_n_o <= 1'b1;
    end else begin
      st_r <= st_nxt;
      go_r <= go_take;
      cnt_r <= (st_nxt != st_r) ?
               ((st_nxt == S_RSTLOW) ? CNT_W'(T_RESET_CYC) :
                (st_nxt == S_RSTWAIT) ? CNT_W'(T_READY_CYC) : CNT_W'(T_STROBE_CYC))
               : (cnt_done ? cnt_r : cnt_r - 1'b1);
      pins_o.id_hv <= idsel_r;
      case (st_nxt)
        S_SETUP: begin
          pins_o.addr <= seq_addr;
          pins_o.ce_n <= 1'b0;
          pins_o.oe_n <= 1'b1;
          pins_o.we_n <= 1'b1;
          dq_o        <= seq_data;
          dq_oe_n_o   <= is_read;
        end
        S_STROBE: begin
          // Write: CE and WE low with OE high; read: OE low, WE high
          pins_o.we_n <= is_read;
          pins_o.oe_n <= ~is_read;
        end
        S_HOLD: begin
          if (is_read && st_r == S_STROBE) begin
            rdata_r <= dq_s2_r;
            fail_r  <= fail_r | fail_seen;
          end
          pins_o.we_n <= 1'b1;
          pins_o.oe_n <= 1'b1;
        end
        S_RSTLOW: pins_o.rst_n <= 1'b0;
        S_RSTWAIT: begin
          pins_o.rst_n <= 1'b1;
          fail_r       <= 1'b0;
        end
        default: begin
          pins_o.ce_n <= 1'b1;
          pins_o.we_n <= 1'b1;
          pins_o.oe_n <= 1'b1;
          dq_oe_n_o   <= 1'b1;
        end
      endcase
      if (st_r == S_HOLD && cnt_done) idx_r <= (st_nxt == S_IDLE) ? 2'h0 : idx_r + 2'h1;
      if (st_r == S_IDLE) idx_r <= 2'h0;
      if (nfc_op_t'(op_r) == OP_SWRESET && st_r == S_HOLD) fail_r <= 1'b0;
    end
  end
endmodule

// ---- test/nfc_checker.sv ----
`timescale 1ns/1ns
// Checks the controller's bus handshake and flash pin discipline
module nfc_checker (
  input wire logic                 clock_i,        // Clock
  input wire logic                 nrst_i,         // Reset, active low
  input wire nfc_pkg::nfc_wb_req_t wb_i,           // Bus request
  input wire logic      [31:0]     wb_dat_o,       // Bus read data
  input wire logic                 wb_ack_o,       // Bus ack
  input wire nfc_pkg::nfc_pins_t   pins_o,         // Flash pins
  input wire logic      [15:0]     dq_o,           // Data out
  input wire logic                 dq_oe_n_o,      // Low drives data
  input wire logic      [15:0]     dq_i,           // Data in
  input wire logic                 ready_busy_n_i, // Ready
  input wire logic                 lockout_i       // Lockout
);
  import nfc_pkg::*;
  logic [15:0] pu_cnt_r;
  logic [15:0] pu_cnt_nxt;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Cycles since reset release, saturating
  assign pu_cnt_nxt = (pu_cnt_r < 16'(T_PWRUP_CYC)) ? pu_cnt_r + 16'h1 : pu_cnt_r;
  always_ff @(posedge clock_i) begin
    if (!nrst_i) pu_cnt_r <= 16'h0;
    else pu_cnt_r <= pu_cnt_nxt;
  end
  property p_ackw; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackw: assert property (p_ackw) else $error("ack longer than one cycle");
  property p_ackr; wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o; endproperty
  a_ackr: assert property (p_ackr) else $error("ack late");
  property p_ackc; wb_ack_o |-> $past(wb_i.cyc && wb_i.stb); endproperty
  a_ackc: assert property (p_ackc) else $error("ack without request");
  property p_wrv; !pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n; endproperty
  a_wrv: assert property (p_wrv) else $error("bad write strobe");
  property p_clash; !pins_o.oe_n |-> dq_oe_n_o; endproperty
  a_clash: assert property (p_clash) else $error("data driven in read");
  property p_pwrup; pu_cnt_r < 16'(T_PWRUP_CYC - 8) |-> pins_o.ce_n; endproperty
  a_pwrup: assert property (p_pwrup) else $error("flash cycle too early");
  property p_wew; $fell(pins_o.we_n) |-> !pins_o.we_n [*3]; endproperty
  a_wew: assert property (p_wew) else $error("strobe too short");
  property p_weh;
    !pins_o.we_n && $past(!pins_o.we_n) |-> $stable(pins_o.addr) && $stable(dq_o) && !dq_oe_n_o;
  endproperty
  a_weh: assert property (p_weh) else $error("write not held");
  property p_rstw; $fell(pins_o.rst_n) |-> !pins_o.rst_n [*8]; endproperty
  a_rstw: assert property (p_rstw) else $error("reset pulse short");
endmodule
bind nfc_ctrl nfc_checker u_chk (.clock_i(clock_i), .nrst_i(nrst_i), .wb_i(wb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins_o), .dq_o(dq_o),
  .dq_oe_n_o(dq_oe_n_o), .dq_i(dq_i), .ready_busy_n_i(ready_busy_n_i), .lockout_i(lockout_i));

// ---- test/nfc_flash_model.sv ----
`timescale 1ns/1ns
// Behavioural flash: command decoder, program engine, id and status reads
module nfc_flash_model #(
  parameter logic [7:0]  MFR_ID   = 8'h5a,   // Arbitrary maker code
  parameter logic [10:0] PROT_SEC = 11'h001, // Protected sector
  parameter logic [7:0]  SEC_IND  = 8'h19,   // Security sector code
  parameter int          PROG_CYC = 400      // Program length in clocks
) (
  input  wire logic               clock_i, // Clock, program timing and released-bus pattern
  input  wire nfc_pkg::nfc_pins_t pins_i,  // Control and address
  input  wire logic [15:0]        dq_i,    // Data from controller
  input  wire logic               lock_i,  // Supply lockout
  input  wire logic               fail_i,  // Make programs fail
  output logic      [15:0]        dq_o,    // Data to controller
  output logic                    rb_n_o   // Ready, low busy
);
  import nfc_pkg::*;
  logic [15:0] mem [logic [22:0]];
  logic [15:0] pd = 16'h0;
  logic [22:0] pa;
  logic [1:0]  step = 2'h0;
  logic        busy = 1'b0, susp = 1'b0, failed = 1'b0, tgl = 1'b0;
  int          cnt;
  time         t_fall;
  wire  [4:0]  lo = {pins_i.addr[6], pins_i.addr[3:0]};
  wire         stat = (busy && !susp) || failed;
  // Ready pin, low while programming, failed or held in reset
  assign rb_n_o = pins_i.rst_n && !stat;
  function automatic logic [15:0] arr(input logic [22:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // Read data; a released bus shows a pattern that flips each half cycle
  always @(pins_i, busy, susp, failed, tgl, clock_i)
    if (pins_i.ce_n || pins_i.oe_n) dq_o = clock_i ? 16'h5a5a : 16'ha5a5;
    else if (pins_i.id_hv) dq_o = (lo == 5'h00) ? {8'h0, MFR_ID} :
      (lo == 5'h02) ? {15'h0, pins_i.addr[22:12] == PROT_SEC} :
      (lo == 5'h03) ? {8'h0, SEC_IND} : 16'h0;
    else if (stat) dq_o = {8'h0, ~pd[7], tgl, failed, 5'h0};
    else dq_o = arr(pins_i.addr);
  // Toggle bit flips at the end of each status read
  always @(posedge pins_i.oe_n) if (stat) tgl = !tgl;
  always @(negedge pins_i.we_n) t_fall = $time;
  // Command decoder, one step per valid write cycle
  always @(posedge pins_i.we_n)
    if (!pins_i.ce_n && pins_i.oe_n && pins_i.rst_n && !lock_i && $time - t_fall >= 5) begin
      if (busy && !susp) susp = dq_i == CMD_SUSPEND;
      else if (susp) susp = dq_i != CMD_RESUME;
      else if (dq_i == CMD_RESET) {step, failed} = 3'h0;
      else if (failed) step = 2'h0;
      else if (step == 2'h3) begin
        pa = pins_i.addr;
        pd = dq_i;
        busy = 1'b1;
        cnt = 0;
        step = 2'h0;
      end else step = (step == 2'h0 && pins_i.addr == UNLOCK1_ADDR && dq_i == UNLOCK1_DATA) ? 2'h1 :
        (step == 2'h1 && pins_i.addr == UNLOCK2_ADDR && dq_i == UNLOCK2_DATA) ? 2'h2 :
        (step == 2'h2 && dq_i == CMD_PROGRAM) ? 2'h3 : 2'h0;
    end
  // Program engine; the reset pin aborts it
  always @(posedge clock_i)
    if (!pins_i.rst_n) {busy, susp, failed, step} = 5'h0;
    else if (busy && !susp && cnt < PROG_CYC) cnt++;
    else if (busy && !susp) begin
      busy = 1'b0;
      failed = fail_i;
      if (!fail_i) mem[pa] = arr(pa) & pd;
    end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ns
// Drives the controller over Wishbone against the flash model
module testbench;
  import nfc_pkg::*;
  localparam logic [7:0] MFR = 8'h3c; // Arbitrary maker code
  logic        clock_i, nrst_i, lockout_i, fail_i, ack, rb_n, dq_oe_n;
  nfc_wb_req_t wb_r;
  nfc_pins_t   pins;
  logic [31:0] dat, rd;
  logic [15:0] dq_o, dq_i;
  int          errors, checks_done;
  nfc_ctrl DUT (.clock_i(clock_i), .nrst_i(nrst_i), .wb_i(wb_r), .wb_dat_o(dat),
    .wb_ack_o(ack), .pins_o(pins), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n), .dq_i(dq_i),
    .ready_busy_n_i(rb_n), .lockout_i(lockout_i));
  nfc_flash_model #(.MFR_ID(MFR)) u_flash (.clock_i(clock_i), .pins_i(pins), .dq_i(dq_o),
    .lock_i(lockout_i), .fail_i(fail_i), .dq_o(dq_i), .rb_n_o(rb_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge clock_i);
    wb_r <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wd};
    @(posedge clock_i);
    while (ack !== 1'b1) @(posedge clock_i);
    rd = dat;
    wb_r <= '0;
  endtask
  task automatic op(input logic [2:0] code, input logic ids, input logic [22:0] a,
                    input logic [15:0] d);
    bus(1'b1, REG_ADDR, {9'h0, a});
    bus(1'b1, REG_WDATA, {16'h0, d});
    bus(1'b1, REG_CTRL, {27'h0, ids, code, 1'b1});
    do bus(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic rdy;
    do bus(1'b0, REG_STATUS, 32'h0); while (rd[ST_RDY_BIT] !== 1'b1);
  endtask
  task automatic t_prog;
    logic [15:0] p;
    op(OP_PROGRAM, 1'b0, 23'h001234, 16'h5a3c);
    op(OP_POLL, 1'b0, 23'h001234, 16'h0);
    p = rd[31:16];
    chk(p & 16'h00a2, 16'h0080);
    chk({15'h0, rd[ST_RDY_BIT]}, 16'h0000);
    op(OP_POLL, 1'b0, 23'h001234, 16'h0);
    chk({15'h0, rd[22] ^ p[6]}, 16'h1);
    rdy();
    op(OP_READ, 1'b0, 23'h001234, 16'h0);
    chk(rd[31:16], 16'h5a3c);
    op(OP_PROGRAM, 1'b0, 23'h001234, 16'ha5f0);
    rdy();
    op(OP_READ, 1'b0, 23'h001234, 16'h0);
    chk(rd[31:16], 16'h0030);
    $display("test program done");
  endtask
  task automatic t_id;
    op(OP_READ, 1'b1, 23'h000000, 16'h0);
    chk(rd[31:16], {8'h0, MFR});
    op(OP_READ, 1'b1, 23'h001002, 16'h0);
    chk(rd[31:16], 16'h0001);
    op(OP_READ, 1'b1, 23'h002002, 16'h0);
    chk(rd[31:16], 16'h0000);
    op(OP_READ, 1'b1, 23'h000003, 16'h0);
    chk(rd[31:16], 16'h0019);
    op(OP_SWRESET, 1'b0, 23'h0, 16'h0);
    op(OP_READ, 1'b0, 23'h001234, 16'h0);
    chk(rd[31:16], 16'h0030);
    $display("test id done");
  endtask
  task automatic t_fail;
    fail_i <= 1'b1;
    op(OP_PROGRAM, 1'b0, 23'h000100, 16'h0000);
    do op(OP_POLL, 1'b0, 23'h000100, 16'h0); while (rd[21] !== 1'b1);
    chk({14'h0, rd[ST_FAIL_BIT], rd[ST_RDY_BIT]}, 16'h0002);
    fail_i <= 1'b0;
    op(OP_HWRESET, 1'b0, 23'h0, 16'h0);
    rdy();
    op(OP_READ, 1'b0, 23'h000100, 16'h0);
    chk(rd[31:16], 16'hffff);
    $display("test fail done");
  endtask
  task automatic t_lock;
    lockout_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    op(OP_PROGRAM, 1'b0, 23'h000200, 16'h0000);
    chk({15'h0, rd[ST_LOCK_BIT]}, 16'h1);
    lockout_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd[15:0], 16'h0002);
    op(OP_READ, 1'b0, 23'h000200, 16'h0);
    chk(rd[31:16], 16'hffff);
    $display("test lockout done");
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    #1500000;
    errors++;
    final_report();
  end
  initial begin
    {nrst_i, lockout_i, fail_i, errors, checks_done} = '0;
    wb_r = '0;
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (T_PWRUP_CYC + 100) @(posedge clock_i);
    t_prog();
    t_id();
    t_fail();
    t_lock();
    final_report();
  end
endmodule
